// File: design/mps_pkg.sv
package mps_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam int NUM_SLOTS = 8;
   localparam int NUM_DEST = 4;
   localparam int ROUTE_W = 4;
   localparam int SLOT_IDX_W = 3;
   localparam int SEG_IDX_W = 2;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_CONFIG = 7'h00;
   localparam logic [ADDR_W-1:0] OFS_TRIGGER_SETUP = 7'h02;
   localparam logic [ADDR_W-1:0] OFS_GEARING = 7'h12;
   localparam logic [ADDR_W-1:0] OFS_POS_COMPARE = 7'h32;
   localparam logic [ADDR_W-1:0] OFS_TARGET = 7'h37;
   localparam logic [ADDR_W-1:0] OFS_SLOT_FIRST = 7'h38;
   localparam logic [ADDR_W-1:0] OFS_SLOT_LAST = 7'h3F;

   // Position of the route-select field inside trigger_setup.
   localparam int ROUTE_LSB = 0;

   // Reset value and read value of unmapped offsets.
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // Destination indices, in route-select bit order.
   localparam int DST_TARGET = 0;
   localparam int DST_POS_COMPARE = 1;
   localparam int DST_GEARING = 2;
   localparam int DST_GLOBAL_CONFIG = 3;

   // Number of enabled destinations.
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_TWO = 3'h2;
   localparam logic [2:0] CNT_THREE = 3'h3;

   localparam logic [SLOT_IDX_W-1:0] THREE_SEG1 = 3'h3;
   localparam logic [SLOT_IDX_W-1:0] THREE_SEG2 = 3'h6;

   // Segment that a slot belongs to, for a given number of segments.
   function automatic logic [SEG_IDX_W-1:0] seg_of(input logic [2:0] cnt,
                                                   input logic [SLOT_IDX_W-1:0] slot);
      logic [SEG_IDX_W-1:0] s;
      s = 2'h0;
      if (cnt == CNT_TWO) begin
         s = {1'b0, slot[2]};
      end else if (cnt == CNT_THREE) begin
         s = (slot < THREE_SEG1) ? 2'h0 : ((slot < THREE_SEG2) ? 2'h1 : 2'h2);
      end else if (cnt > CNT_THREE) begin
         s = slot[2:1];
      end
      return s;
   endfunction : seg_of

   // Output slot of a segment, for a given number of segments.
   function automatic logic [SLOT_IDX_W-1:0] seg_base(input logic [2:0] cnt,
                                                      input logic [SEG_IDX_W-1:0] seg);
      logic [SLOT_IDX_W-1:0] b;
      b = 3'h0;
      if (cnt == CNT_TWO) begin
         b = {seg[0], 2'h0};
      end else if (cnt == CNT_THREE) begin
         b = (seg == 2'h0) ? 3'h0 : ((seg == 2'h1) ? THREE_SEG1 : THREE_SEG2);
      end else if (cnt > CNT_THREE) begin
         b = {seg, 1'b0};
      end
      return b;
   endfunction : seg_base
endpackage : mps_pkg

// File: design/mps_word_reg.sv
`timescale 1ns/1ns
module mps_word_reg #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Load strobe and data.
   input wire logic load,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else if (load) begin
         q <= d;
      end
   end
endmodule : mps_word_reg

// File: design/mps_top.sv
// Notes on behaviour
// R01 - Assignment cycle only on internal start, pipelining on
// R02 - Target takes slot 0, slots shift down
// R03 - Loopback mask writes destination value into slot
// R04 - Eight consecutive slots, up to four segments
// R05 - Destinations: target, compare, gearing, global config
// R06 - Route bits enable destinations; zero disables
// R07 - All sixteen combinations; one gives eight stages
// R08 - Two destinations: slots 0 and 4
// R09 - Three destinations: slots 0, 3, 6
// R10 - Four destinations: slots 0, 2, 4, 6
// R11 - Host may pipeline close compare points
// R12 - Segments shift to output; last slot holds
// R13 - Untouched slots keep value until host write
`timescale 1ns/1ns
module mps_top #(
   parameter int DATA_W = mps_pkg::DATA_W,
   parameter int NUM_SLOTS = mps_pkg::NUM_SLOTS
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Register access.
   input wire logic [mps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   // Internal start event and loopback selection.
   input wire logic start_pulse,
   input wire logic [NUM_SLOTS-1:0] loopback_slot_mask,
   // Destination values and trigger setup.
   output logic [DATA_W-1:0] target_position,
   output logic [DATA_W-1:0] position_compare_value,
   output logic [DATA_W-1:0] step_gearing_factor,
   output logic [DATA_W-1:0] global_config_word,
   output logic [DATA_W-1:0] trigger_setup
);
   localparam int ND = mps_pkg::NUM_DEST;

   logic [DATA_W-1:0] slot_q [NUM_SLOTS];
   logic [DATA_W-1:0] slot_d [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] slot_ld;
   logic [DATA_W-1:0] dest_q [ND];
   logic [DATA_W-1:0] dest_d [ND];
   logic [ND-1:0] dest_ld;
   logic [ND-1:0] dest_hit;
   logic [mps_pkg::ADDR_W-1:0] dest_ofs [ND];
   logic [DATA_W-1:0] trig_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [mps_pkg::ROUTE_W-1:0] route;
   logic assign_cycle;
   logic [2:0] seg_cnt;
   logic [1:0] seg_dest [ND];
   logic [1:0] dest_seg [ND];
   wire slot_range = (reg_addr >= mps_pkg::OFS_SLOT_FIRST) &&
                     (reg_addr <= mps_pkg::OFS_SLOT_LAST);
   wire [mps_pkg::ADDR_W-1:0] slot_rel = reg_addr - mps_pkg::OFS_SLOT_FIRST;
   wire [mps_pkg::SLOT_IDX_W-1:0] slot_sel = slot_rel[mps_pkg::SLOT_IDX_W-1:0];
   wire trig_hit = reg_addr == mps_pkg::OFS_TRIGGER_SETUP;

   assign dest_ofs[mps_pkg::DST_TARGET] = mps_pkg::OFS_TARGET;
   assign dest_ofs[mps_pkg::DST_POS_COMPARE] = mps_pkg::OFS_POS_COMPARE;
   assign dest_ofs[mps_pkg::DST_GEARING] = mps_pkg::OFS_GEARING;
   assign dest_ofs[mps_pkg::DST_GLOBAL_CONFIG] = mps_pkg::OFS_GLOBAL_CONFIG;

   assign route = trig_q[mps_pkg::ROUTE_LSB +: mps_pkg::ROUTE_W]; // R06
   assign assign_cycle = start_pulse && (route != '0); // R01 R06

   // Orders the enabled destinations onto segments in rising bit order.
   always_comb begin // R07
      seg_cnt = 3'h0;
      for (int k = 0; k < ND; k++) begin
         seg_dest[k] = 2'h0;
         dest_seg[k] = 2'h0;
      end
      for (int k = 0; k < ND; k++) begin
         if (route[k]) begin
            seg_dest[seg_cnt[1:0]] = 2'(k);
            dest_seg[k] = seg_cnt[1:0];
            seg_cnt = seg_cnt + 3'h1;
         end
      end
   end

   // Staging slots.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
         localparam logic [mps_pkg::SLOT_IDX_W-1:0] IDX = mps_pkg::SLOT_IDX_W'(gi);
         wire [1:0] my_seg = mps_pkg::seg_of(seg_cnt, IDX); // R04
         wire is_last;
         wire [DATA_W-1:0] shift_val;
         wire [DATA_W-1:0] loop_val = dest_q[seg_dest[my_seg]]; // R03
         wire host_wr = reg_wr && slot_range && (slot_sel == IDX);
         if (gi == NUM_SLOTS - 1) begin : g_end
            assign is_last = 1'b1;
            assign shift_val = slot_q[gi];
         end else begin : g_mid
            localparam logic [mps_pkg::SLOT_IDX_W-1:0] NXT = mps_pkg::SLOT_IDX_W'(gi + 1);
            assign is_last = mps_pkg::seg_of(seg_cnt, NXT) != my_seg; // R12
            assign shift_val = slot_q[gi + 1]; // R02
         end
         assign slot_d[gi] = host_wr ? reg_wdata :
                             loopback_slot_mask[gi] ? loop_val : // R03
                             is_last ? slot_q[gi] : shift_val; // R12
         assign slot_ld[gi] = host_wr || assign_cycle; // R13
         mps_word_reg #(.WIDTH(DATA_W), .RST_VAL(mps_pkg::RST_WORD)) u_slot (
            .mclk(mclk),
            .rst_n(rst_n),
            .load(slot_ld[gi]),
            .d(slot_d[gi]),
            .q(slot_q[gi])
         );
      end

      // Destination registers fed from their segment's output slot.
      for (gi = 0; gi < ND; gi++) begin : g_dest
         wire [mps_pkg::SLOT_IDX_W-1:0] src = mps_pkg::seg_base(seg_cnt, dest_seg[gi]);
         assign dest_hit[gi] = reg_wr && (reg_addr == dest_ofs[gi]);
         assign dest_d[gi] = dest_hit[gi] ? reg_wdata : slot_q[src]; // R05 R08 R09 R10
         assign dest_ld[gi] = dest_hit[gi] || (assign_cycle && route[gi]); // R01 R06
         mps_word_reg #(.WIDTH(DATA_W), .RST_VAL(mps_pkg::RST_WORD)) u_dest (
            .mclk(mclk),
            .rst_n(rst_n),
            .load(dest_ld[gi]),
            .d(dest_d[gi]),
            .q(dest_q[gi])
         );
      end
   endgenerate

   mps_word_reg #(.WIDTH(DATA_W), .RST_VAL(mps_pkg::RST_WORD)) u_trig (
      .mclk(mclk),
      .rst_n(rst_n),
      .load(reg_wr && trig_hit),
      .d(reg_wdata),
      .q(trig_q)
   );

   // Read decode; unmapped offsets read zero.
   always_comb begin
      rdata_d = mps_pkg::READ_ZERO;
      if (slot_range) begin
         rdata_d = slot_q[slot_sel];
      end else if (trig_hit) begin
         rdata_d = trig_q;
      end
      for (int k = 0; k < ND; k++) begin
         if (reg_addr == dest_ofs[k]) begin
            rdata_d = dest_q[k];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= mps_pkg::RST_WORD;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign target_position = dest_q[mps_pkg::DST_TARGET];
   assign position_compare_value = dest_q[mps_pkg::DST_POS_COMPARE];
   assign step_gearing_factor = dest_q[mps_pkg::DST_GEARING];
   assign global_config_word = dest_q[mps_pkg::DST_GLOBAL_CONFIG];
   assign trigger_setup = trig_q;

   AST_HOLD_NO_START: assert property (@(posedge mclk) disable iff (!rst_n) // R01
      !start_pulse && !reg_wr |=> $stable(slot_q[2]) && $stable(dest_q[0]))
      else $error("State changed without start or write.");
   AST_TARGET_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // R02
      start_pulse && !reg_wr && route == 4'h1 |=> dest_q[0] == $past(slot_q[0]))
      else $error("Target did not take slot 0.");
   AST_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n) // R02
      start_pulse && !reg_wr && route == 4'h1 && loopback_slot_mask == 8'h00
      |=> slot_q[3] == $past(slot_q[4]) && slot_q[7] == $past(slot_q[7]))
      else $error("Eight-stage shift wrong.");
   AST_LOOPBACK: assert property (@(posedge mclk) disable iff (!rst_n) // R03
      start_pulse && !reg_wr && route == 4'h1 && loopback_slot_mask == 8'h10
      |=> slot_q[4] == $past(dest_q[0]))
      else $error("Loopback into slot 4 wrong.");
   AST_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // R06
      start_pulse && !reg_wr && route == 4'h0 |=> $stable(dest_q[1]) && $stable(slot_q[0]))
      else $error("Pipeline moved while disabled.");
   AST_TWO_SEG: assert property (@(posedge mclk) disable iff (!rst_n) // R08
      start_pulse && !reg_wr && route == 4'h6
      |=> dest_q[1] == $past(slot_q[0]) && dest_q[2] == $past(slot_q[4]))
      else $error("Two-segment mapping wrong.");
   AST_THREE_SEG: assert property (@(posedge mclk) disable iff (!rst_n) // R09
      start_pulse && !reg_wr && route == 4'h7
      |=> dest_q[1] == $past(slot_q[3]) && dest_q[2] == $past(slot_q[6]))
      else $error("Three-segment mapping wrong.");
   AST_FOUR_SEG: assert property (@(posedge mclk) disable iff (!rst_n) // R10
      start_pulse && !reg_wr && route == 4'hF
      |=> dest_q[1] == $past(slot_q[2]) && dest_q[3] == $past(slot_q[6]))
      else $error("Four-segment mapping wrong.");
   AST_SEG_LAST: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      start_pulse && !reg_wr && route == 4'h3 && loopback_slot_mask == 8'h00
      |=> slot_q[3] == $past(slot_q[3]) && slot_q[2] == $past(slot_q[3]))
      else $error("Segment end not held.");
   // Register writes take priority over the pipeline and reach the read path.
   AST_HOST_SLOT: assert property (@(posedge mclk) disable iff (!rst_n) // R13
      reg_wr && reg_addr == mps_pkg::OFS_SLOT_FIRST |=> slot_q[0] == $past(reg_wdata))
      else $error("Host write to slot 0 lost.");
   AST_HOST_DEST: assert property (@(posedge mclk) disable iff (!rst_n) // R05
      reg_wr && reg_addr == mps_pkg::OFS_POS_COMPARE |=> dest_q[1] == $past(reg_wdata))
      else $error("Host write to compare value lost.");
   AST_ROUTE_WRITE: assert property (@(posedge mclk) disable iff (!rst_n) // R06
      reg_wr && reg_addr == mps_pkg::OFS_TRIGGER_SETUP
      |=> route == $past(reg_wdata[mps_pkg::ROUTE_LSB +: mps_pkg::ROUTE_W]))
      else $error("Route select not stored.");
   AST_READ_SLOT: assert property (@(posedge mclk) disable iff (!rst_n) // R04
      reg_rd && reg_addr == mps_pkg::OFS_SLOT_LAST |=> reg_rdata == $past(slot_q[7]))
      else $error("Read of last slot wrong.");
   AST_ONE_SEG: assert property (@(posedge mclk) disable iff (!rst_n) // R07
      start_pulse && !reg_wr && route == 4'h2
      |=> dest_q[1] == $past(slot_q[0]) && $stable(dest_q[0]))
      else $error("Single compare pipeline wrong.");
   AST_LOOP_THREE: assert property (@(posedge mclk) disable iff (!rst_n) // R03
      start_pulse && !reg_wr && route == 4'h7 && loopback_slot_mask == 8'h10
      |=> slot_q[4] == $past(dest_q[1]))
      else $error("Loopback in three segments wrong.");
   AST_LOOP_FOUR: assert property (@(posedge mclk) disable iff (!rst_n) // R03
      start_pulse && !reg_wr && route == 4'hF && loopback_slot_mask == 8'h10
      |=> slot_q[4] == $past(dest_q[2]))
      else $error("Loopback in four segments wrong.");
   AST_TWO_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      start_pulse && !reg_wr && route == 4'h6 && loopback_slot_mask == 8'h00
      |=> slot_q[4] == $past(slot_q[5]) && slot_q[7] == $past(slot_q[7]))
      else $error("Two-segment shift wrong.");
endmodule : mps_top

// File: bench/mps_top_tb.sv
`timescale 1ns/1ns
module mps_top_tb;
   logic mclk;
   logic rst_n;
   logic [mps_pkg::ADDR_W-1:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic start_pulse;
   logic [7:0] loopback_slot_mask;
   logic [31:0] dq [4];
   logic [31:0] ms [8];
   logic [31:0] md [4];
   logic [31:0] rv;
   logic [31:0] ts;
   logic [7:0] m;
   int n_errors;
   int checks_done;
   localparam logic [6:0] DA [5] = '{mps_pkg::OFS_TARGET, mps_pkg::OFS_POS_COMPARE,
      mps_pkg::OFS_GEARING, mps_pkg::OFS_GLOBAL_CONFIG, mps_pkg::OFS_TRIGGER_SETUP};

   mps_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .start_pulse(start_pulse), .loopback_slot_mask(loopback_slot_mask),
      .target_position(dq[0]), .position_compare_value(dq[1]),
      .step_gearing_factor(dq[2]), .global_config_word(dq[3]), .trigger_setup(ts));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Reference step of the staging pipeline for one start event.
   task automatic step(input logic [3:0] r, input logic [7:0] mk);
      int c;
      int e;
      int b [4];
      int dd [4];
      int own [8];
      logic [31:0] ns [8];
      c = 0;
      for (int d = 0; d < 4; d++) if (r[d]) begin
         dd[c] = d;
         c++;
      end
      if (c == 0) return;
      for (int k = 0; k < c; k++) b[k] = (c == 1) ? 0 : (c == 2) ? 4 * k : (c == 3) ? 3 * k : 2 * k;
      for (int k = 0; k < c; k++) begin
         e = (k == c - 1) ? 7 : b[k + 1] - 1;
         for (int n = b[k]; n <= e; n++) begin
            own[n] = dd[k];
            ns[n] = (n < e) ? ms[n + 1] : ms[n];
         end
      end
      for (int n = 0; n < 8; n++) if (mk[n]) ns[n] = md[own[n]];
      for (int k = 0; k < c; k++) md[dd[k]] = ms[b[k]];
      ms = ns;
   endtask : step

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      close_out();
   end

   initial begin
      n_errors = 0;
      checks_done = 0;
      rst_n = 1'b0;
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
      start_pulse = 1'b0;
      loopback_slot_mask = 8'h00;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         rd((i < 5) ? DA[i] : mps_pkg::OFS_SLOT_FIRST + 7'(i - 5), rv);
         chk("reset value", rv, 32'h0000_0000);
      end
      wr(7'h01, 32'hDEAD_BEEF);
      rd(7'h01, rv);
      chk("unmapped", rv, 32'h0000_0000);
      // Every route code, two back-to-back starts each, with loopback.
      for (int r = 0; r < 16; r++) begin
         m = r[0] ? 8'h10 : 8'h41;
         @(posedge mclk);
         loopback_slot_mask <= m;
         for (int d = 0; d < 4; d++) begin
            md[d] = {8'(r), 8'(d + 16), 16'h5AA5};
            wr(DA[d], md[d]);
         end
         for (int n = 0; n < 8; n++) begin
            ms[n] = {8'(r), 8'(n), 16'hA55A};
            wr(mps_pkg::OFS_SLOT_FIRST + 7'(n), ms[n]);
         end
         wr(mps_pkg::OFS_TRIGGER_SETUP, 32'h5A00_0000 | 32'(r));
         @(posedge mclk);
         start_pulse <= 1'b1;
         @(posedge mclk);
         loopback_slot_mask <= 8'h00;
         @(posedge mclk);
         start_pulse <= 1'b0;
         step(4'(r), m);
         step(4'(r), 8'h00);
         for (int d = 0; d < 4; d++) begin
            rd(DA[d], rv);
            chk("destination out", dq[d], md[d]);
            chk("destination reg", rv, md[d]);
         end
         for (int n = 0; n < 8; n++) begin
            rd(mps_pkg::OFS_SLOT_FIRST + 7'(n), rv);
            chk("slot", rv, ms[n]);
         end
         rd(mps_pkg::OFS_TRIGGER_SETUP, rv);
         chk("trigger setup", rv, 32'h5A00_0000 | 32'(r));
         chk("trigger setup out", ts, 32'h5A00_0000 | 32'(r));
      end
      close_out();
   end
endmodule : mps_top_tb
